// ==== rtl/dppwm_pkg.sv ====
// dppwm_pkg: widths, reset values and state codes for the dual pair pwm block.
// assumes a single 100 MHz clock domain; no register bus, every setting is a port.
package dppwm_pkg;

    // clock of the block, used to express figures in cycles
    localparam int CLK_PERIOD_NS = 10;

    // counter and setting widths
    localparam int CNT_W      = 16;               // up counter, period and duty width
    localparam int DBA_W      = 8;                // leading dead-band width
    localparam int DIV_SEL_W  = 3;                // divider selection field width
    localparam int DIV_CNT_W  = 7;                // prescaler counter, ratio up to 128
    localparam int NUM_CH     = 4;                // output channels, two pairs of two
    localparam int NUM_PAIR   = 2;                // output pairs

    // divider: code 000 divides by 128, code 111 divides by 1
    localparam logic [DIV_CNT_W-1:0] DIV_MASK_MAX = 7'h7F;

    // reset values of the held state
    localparam logic [CNT_W-1:0]     CNT_RST      = 16'h0000;
    localparam logic [CNT_W-1:0]     PERIOD_RST   = 16'h0000;
    localparam logic [CNT_W-1:0]     DUTY_RST     = 16'h0000;
    localparam logic [DBA_W-1:0]     DBA_RST      = 8'h00;
    localparam logic [CNT_W-1:0]     DBB_RST      = 16'h0000;
    localparam logic [DIV_CNT_W-1:0] DIV_CNT_RST  = 7'h00;
    localparam logic [NUM_CH-1:0]    PIN_RST      = 4'h0;
    localparam logic                 FLAG_RST     = 1'b0;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        DPPWM_ST_IDLE = 3'b001,                  // run enable low, pins on gpio
        DPPWM_ST_SYNC = 3'b010,                  // started, waiting for first tick
        DPPWM_ST_RUN  = 3'b100                   // counting, pins may carry pwm
    } dppwm_state_type;

endpackage

// ==== rtl/dppwm_tick_div.sv ====
// dppwm_tick_div: prescaler that turns the oscillator clock into a tick enable.
// assumes the caller holds it cleared while the timer is stopped.
module dppwm_tick_div #(
    parameter int SEL_W = dppwm_pkg::DIV_SEL_W,
    parameter int CNT_W = dppwm_pkg::DIV_CNT_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             clear,
    input  wire logic [SEL_W-1:0] divider_select,
    // tick enable, one clock wide; high on every clock at code 111
    output logic                  tick
);
    import dppwm_pkg::*;

    logic [CNT_W-1:0] div_cnt_q;                 // free running prescaler count
    logic [CNT_W-1:0] div_cnt_d;                 // next prescaler count
    logic [CNT_W-1:0] div_mask;                  // low bits that must all be ones

    // each code step up halves the ratio: mask shrinks by one bit
    assign div_mask  = CNT_W'(DIV_MASK_MAX >> divider_select);
    // tick when the masked bits are all ones; mask of zero ticks every clock
    assign tick      = ~clear && ((div_cnt_q & div_mask) == div_mask);
    assign div_cnt_d = clear ? DIV_CNT_RST : CNT_W'(div_cnt_q + 1'b1);

    // prescaler count; restarting on clear gives a full first tick period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= DIV_CNT_RST;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

endmodule

// ==== rtl/dppwm_core.sv ====
// dppwm_core: 16-bit up counting pwm timer with two output pairs, dead band,
// per-pair inversion, single-shot mode, period flag and idle wake-up request.
// assumes all inputs are synchronous to clk; gpio_level carries the last gpio
// state of each shared pin, and the pin mux outside takes pair*_out when
// pin_pwm_mode is high.
module dppwm_core (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    // run enable write port
    input  wire logic                                 run_enable_wr,
    input  wire logic                                 run_enable_wdata,
    // period flag write port
    input  wire logic                                 period_flag_wr,
    input  wire logic                                 period_flag_wdata,
    // configuration
    input  wire logic [dppwm_pkg::DIV_SEL_W-1:0]      divider_select,
    input  wire logic                                 single_shot_select,
    input  wire logic [dppwm_pkg::NUM_PAIR-1:0]       pair_invert,
    input  wire logic [dppwm_pkg::NUM_CH-1:0]         channel_pin_select,
    input  wire logic                                 period_irq_enable,
    // timing settings
    input  wire logic [dppwm_pkg::CNT_W-1:0]          period_limit,
    input  wire logic [dppwm_pkg::CNT_W-1:0]          duty_compare,
    input  wire logic [dppwm_pkg::DBA_W-1:0]          deadband_a,
    input  wire logic [dppwm_pkg::CNT_W-1:0]          deadband_b,
    // system side
    input  wire logic                                 core_idle,
    input  wire logic [dppwm_pkg::NUM_CH-1:0]         gpio_level,
    // status
    output logic                                      run_enable,
    output logic                                      period_flag,
    output logic [dppwm_pkg::CNT_W-1:0]               tick_counter,
    output logic                                      period_irq,
    output logic                                      wake_req,
    // pins
    output logic [dppwm_pkg::NUM_CH-1:0]              pin_pwm_mode,
    output logic                                      pair1_out_a,
    output logic                                      pair1_out_b,
    output logic                                      pair2_out_a,
    output logic                                      pair2_out_b
);
    import dppwm_pkg::*;

    // reset release synchroniser
    logic                  rst_meta_q;           // first stage, read only by second
    logic                  rst_n_q;              // released reset used everywhere

    // sequencer and timer state
    dppwm_state_type       state_q;              // current sequencer state
    dppwm_state_type       state_d;              // next sequencer state
    logic [CNT_W-1:0]      cnt_q;                // tick counter
    logic [CNT_W-1:0]      cnt_d;                // next tick counter
    logic [CNT_W-1:0]      period_q;             // period in use this cycle
    logic [CNT_W-1:0]      period_d;             // next period in use
    logic [CNT_W-1:0]      duty_q;               // duty in use this cycle
    logic [CNT_W-1:0]      duty_d;               // next duty in use
    logic                  flag_q;               // period flag
    logic                  flag_d;               // next period flag
    logic [NUM_CH-1:0]     pin_q;                // registered pin levels
    logic [NUM_CH-1:0]     pin_d;                // next pin levels
    logic [NUM_CH-1:0]     mode_q;               // registered pwm mode per pin
    logic [NUM_CH-1:0]     mode_d;               // next pwm mode per pin

    // decoded conditions
    logic                  tick;                 // counter advance enable
    logic                  stopped;              // sequencer idle
    logic                  running;              // sequencer counting
    logic                  start_req;            // software sets run enable
    logic                  start_ok;             // start with a usable period
    logic                  stop_req;             // software clears run enable
    logic                  overflow;             // last count of the period
    logic                  shot_end;             // single-shot pulse complete
    logic [CNT_W-1:0]      last_cnt;             // period minus one
    logic                  raw_pwm;              // basic duty waveform
    logic [CNT_W-1:0]      lead_end;             // start of shaped pulse
    logic [CNT_W-1:0]      trail_start;          // end of shaped pulse
    logic                  no_pulse;             // dead time swallows the pulse
    logic                  shaped_a;             // a side after dead band
    logic                  shaped_b;             // b side after dead band
    logic [NUM_CH-1:0]     chan_wave;            // waveform per channel

    // returns the smaller of two counter values; used by the dead-band window
    function automatic logic [CNT_W-1:0] min_cnt(input logic [CNT_W-1:0] x,
                                                 input logic [CNT_W-1:0] y);
        min_cnt = (x < y) ? x : y;
    endfunction

    // reset: asserted at once, released after two clocks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // prescaler held cleared while stopped so the first tick is a full one
    dppwm_tick_div #(
        .SEL_W (DIV_SEL_W),
        .CNT_W (DIV_CNT_W)
    ) u_tick_div (
        .clk            (clk),
        .rst_n          (rst_n_q),
        .clear          (stopped),
        .divider_select (divider_select),
        .tick           (tick)
    );

    // sequencer decodes
    assign stopped   = (state_q == DPPWM_ST_IDLE);
    assign running   = (state_q == DPPWM_ST_RUN);
    assign start_req = run_enable_wr && run_enable_wdata;
    assign stop_req  = run_enable_wr && !run_enable_wdata;
    // a zero period refuses the start and its settings are not taken
    assign start_ok  = start_req && (period_limit != PERIOD_RST);

    // counter decodes; period of N ticks counts 0 .. N-1
    assign last_cnt  = CNT_W'(period_q - 1'b1);
    assign overflow  = running && tick && (cnt_q == last_cnt);
    // single-shot ends on its first overflow
    assign shot_end  = overflow && single_shot_select;

    // next sequencer state; a software clear of run enable is checked before auto stop
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DPPWM_ST_IDLE: begin
                if (start_ok) begin
                    state_d = DPPWM_ST_SYNC;
                end
            end
            DPPWM_ST_SYNC: begin
                if (stop_req) begin
                    state_d = DPPWM_ST_IDLE;
                end else if (tick) begin
                    state_d = DPPWM_ST_RUN;             // output synchronised
                end
            end
            DPPWM_ST_RUN: begin
                if (stop_req) begin
                    state_d = DPPWM_ST_IDLE;
                end else if (shot_end) begin
                    state_d = DPPWM_ST_IDLE;            // auto clear of run
                end
                // continuous mode keeps running while run enable holds
            end
            default: begin
                state_d = DPPWM_ST_IDLE;                // illegal code recovers
            end
        endcase
    end

    // counter: zero while stopped, advances only on ticks
    always_comb begin
        cnt_d = cnt_q;
        if (!running) begin
            cnt_d = CNT_RST;
        end else if (overflow) begin
            cnt_d = CNT_RST;                            // restart from zero
        end else if (tick) begin
            cnt_d = CNT_W'(cnt_q + 1'b1);
        end
    end

    // period and duty are taken at start and again at each period boundary,
    // so a mid-cycle write cannot tear the waveform; a zero period is refused
    always_comb begin
        period_d = period_q;
        duty_d   = duty_q;
        if (stopped && start_ok) begin
            period_d = period_limit;
            duty_d   = duty_compare;
        end else if (overflow && (period_limit != PERIOD_RST)) begin
            period_d = period_limit;
            duty_d   = duty_compare;
        end
    end

    // period flag: hardware set wins over a software clear in the same cycle
    always_comb begin
        flag_d = flag_q;
        if (period_flag_wr) begin
            flag_d = period_flag_wdata;                 // firmware access
        end
        if (overflow) begin
            flag_d = 1'b1;                              // set at once
        end
    end

    // interrupt is gated by the enable; wake-up only while the core idles
    assign period_irq = flag_q && period_irq_enable;
    assign wake_req   = period_irq && core_idle;

    // basic waveform: high from zero until the count meets the duty value,
    // which gives duty ticks high and period minus duty ticks low
    assign raw_pwm = (cnt_q < duty_q);

    // dead band sits inside the high pulse: leading part from deadband_a,
    // trailing part is duty minus deadband_b (none when b is not below duty)
    assign lead_end    = CNT_W'(deadband_a);
    assign trail_start = min_cnt(deadband_b, duty_q);
    // when the dead time covers the whole high time no pulse is sent
    assign no_pulse    = (lead_end >= trail_start);

    // a side: shrunken high pulse; b side: low part, so the dead times sit
    // between the a falling edge and b rising edge, and at the cycle start
    assign shaped_a = !no_pulse && (cnt_q >= lead_end) && (cnt_q < trail_start);
    assign shaped_b = !no_pulse && !raw_pwm;

    // channel waveforms with per-pair inversion; even channel is side a
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
            if ((gi % 2) == 0) begin : g_side_a
                assign chan_wave[gi] = shaped_a ^ pair_invert[gi/2];
            end else begin : g_side_b
                assign chan_wave[gi] = shaped_b ^ pair_invert[gi/2];
            end
        end
    endgenerate

    // pin selection: a pin takes pwm only when selected, running and past
    // the first tick; otherwise it shows the last gpio state
    always_comb begin
        mode_d = channel_pin_select & {NUM_CH{running && !shot_end && !stop_req}};
        pin_d  = (mode_d & chan_wave) | (~mode_d & gpio_level);
    end
    // note: mode drops in the same cycle as the overflow that ends a single
    // shot, so the pins never show a second high edge

    // sequencer and counter registers
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= DPPWM_ST_IDLE;
            cnt_q   <= CNT_RST;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // cycle settings in use
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            period_q <= PERIOD_RST;
            duty_q   <= DUTY_RST;
        end else begin
            period_q <= period_d;
            duty_q   <= duty_d;
        end
    end

    // flag register
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flag_q <= FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // pin registers; pins and modes come straight from flip-flops so the
    // external mux sees no glitches from the compare logic
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_q  <= PIN_RST;
            mode_q <= PIN_RST;
        end else begin
            pin_q  <= pin_d;
            mode_q <= mode_d;
        end
    end

    // status outputs
    assign run_enable   = !stopped;
    assign period_flag  = flag_q;
    assign tick_counter = cnt_q;

    // pin outputs
    assign pin_pwm_mode = mode_q;
    assign pair1_out_a  = pin_q[0];
    assign pair1_out_b  = pin_q[1];
    assign pair2_out_a  = pin_q[2];
    assign pair2_out_b  = pin_q[3];

endmodule

// ==== sim/dppwm_core_asserts.sv ====
// dppwm_core_asserts: port level checks on the dual pair pwm core.
// assumes one clock domain; bound to every dppwm_core instance.
module dppwm_core_asserts (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          reset_n,
    // write ports and settings
    input wire logic                          run_enable_wr,
    input wire logic                          run_enable_wdata,
    input wire logic                          period_flag_wr,
    input wire logic                          period_flag_wdata,
    input wire logic                          single_shot_select,
    input wire logic [dppwm_pkg::NUM_CH-1:0]  channel_pin_select,
    input wire logic                          period_irq_enable,
    input wire logic [dppwm_pkg::CNT_W-1:0]   period_limit,
    input wire logic                          core_idle,
    input wire logic [dppwm_pkg::NUM_CH-1:0]  gpio_level,
    // status and pins
    input wire logic                          run_enable,
    input wire logic                          period_flag,
    input wire logic [dppwm_pkg::CNT_W-1:0]   tick_counter,
    input wire logic                          period_irq,
    input wire logic                          wake_req,
    input wire logic [dppwm_pkg::NUM_CH-1:0]  pin_pwm_mode,
    input wire logic                          pair1_out_a,
    input wire logic                          pair1_out_b,
    input wire logic                          pair2_out_a,
    input wire logic                          pair2_out_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins in select bit order
    wire  [3:0] pins_w = {pair2_out_b, pair2_out_a, pair1_out_b, pair1_out_a};
    // the core releases its reset two edges late, so checks wait a little longer
    logic [2:0] up_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) up_q <= 3'h0;
        else if (up_q != 3'h4) up_q <= up_q + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    // reset_n in the guard keeps checks off before up_q has its first known value
    default disable iff (!reset_n || up_q != 3'h4);

    a_pin_gpio: assert property (((pins_w ^ $past(gpio_level)) & ~pin_pwm_mode) == 4'h0)
        else $error("unselected pin differs from gpio level");
    a_mode_select: assert property ((pin_pwm_mode & ~$past(channel_pin_select)) == 4'h0)
        else $error("pwm mode on a deselected pin");
    a_mode_run: assert property (|pin_pwm_mode |-> $past(run_enable))
        else $error("pwm mode without run enable");
    a_sync_first: assert property ($rose(run_enable) |-> pin_pwm_mode == 4'h0)
        else $error("pin switched before sync");
    a_irq_gate: assert property (period_irq == (period_flag && period_irq_enable))
        else $error("interrupt gate wrong");
    a_wake_gate: assert property (wake_req == (period_irq && core_idle))
        else $error("wake request gate wrong");
    a_count_step: assert property (tick_counter != $past(tick_counter) |->
        tick_counter == $past(tick_counter) + 16'h0001 || tick_counter == 16'h0000)
        else $error("counter jumped");
    a_wrap_zero: assert property ($rose(period_flag) && !$past(period_flag_wr) |->
        tick_counter == 16'h0000) else $error("flag set without wrap");
    a_stop_hold: assert property (!run_enable [*2] |-> tick_counter == 16'h0000)
        else $error("counter moves while stopped");
    a_flag_write: assert property (period_flag_wr && !run_enable |=>
        period_flag == $past(period_flag_wdata)) else $error("flag write lost");
    a_shot_stop: assert property ($rose(period_flag) && $past(single_shot_select) &&
        $past(run_enable) && !$past(period_flag_wr) && !$past(run_enable_wr) |->
        !run_enable && pin_pwm_mode == 4'h0) else $error("single shot did not stop");
    a_cont_run: assert property (run_enable && !run_enable_wr && !single_shot_select |=>
        run_enable) else $error("continuous run stopped");
    a_zero_refuse: assert property (run_enable_wr && run_enable_wdata && !run_enable &&
        period_limit == 16'h0000 |=> !run_enable) else $error("zero period started");

    // main scenarios reached
    c_shot: cover property ($fell(run_enable) && single_shot_select);
    c_wake: cover property (wake_req);
    c_mode: cover property ($rose(pin_pwm_mode[0]));
    c_refuse: cover property (run_enable_wr && run_enable_wdata && period_limit == 16'h0000);
endmodule

bind dppwm_core dppwm_core_asserts i_dppwm_core_asserts (.clk(clk), .reset_n(reset_n),
    .run_enable_wr(run_enable_wr), .run_enable_wdata(run_enable_wdata),
    .period_flag_wr(period_flag_wr), .period_flag_wdata(period_flag_wdata),
    .single_shot_select(single_shot_select), .channel_pin_select(channel_pin_select),
    .period_irq_enable(period_irq_enable), .period_limit(period_limit),
    .core_idle(core_idle), .gpio_level(gpio_level), .run_enable(run_enable),
    .period_flag(period_flag), .tick_counter(tick_counter), .period_irq(period_irq),
    .wake_req(wake_req), .pin_pwm_mode(pin_pwm_mode), .pair1_out_a(pair1_out_a),
    .pair1_out_b(pair1_out_b), .pair2_out_a(pair2_out_a), .pair2_out_b(pair2_out_b));

// ==== sim/dppwm_load.sv ====
// dppwm_load: driver stage stand-in that counts high samples on each pin.
// assumes pins are sampled on the rising edge while en is high.
module dppwm_load (
    // clock and control
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        en,
    // pins: pair1 a, pair1 b, pair2 a, pair2 b
    input  wire logic [3:0]  pins,
    // high samples per pin, compared against duty and dead band
    output logic [3:0][15:0] hi_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // a window of whole periods gives counts that do not depend on phase
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (clr) hi_cnt[i] <= 16'h0000;
            else if (en && pins[i]) hi_cnt[i] <= hi_cnt[i] + 16'h0001;
        end
    end
endmodule

// ==== sim/dppwm_core_bench.sv ====
// dppwm_core_bench: random and corner runs of the pwm core into a load model.
// assumes dppwm_pkg, the core, checker and load model are compiled first.
module dppwm_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dppwm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, run_wr = 1'b0, run_wd = 1'b0;
    logic flag_wr = 1'b0, flag_wd = 1'b0, shot = 1'b0, irq_en = 1'b0, idle = 1'b0;
    logic [2:0] div_sel = 3'h7;
    logic [1:0] inv = 2'h0;
    logic [3:0] sel = 4'h0, gpio = 4'h0;
    logic [15:0] per = 16'h0000, duty = 16'h0000, dbb = 16'h0000;
    logic [7:0] dba = 8'h00;
    logic ld_clr = 1'b0, ld_en = 1'b0;
    wire run_enable, period_flag, period_irq, wake_req;
    wire [15:0] tick_counter;
    wire [3:0] pin_pwm_mode, pv;
    wire [3:0][15:0] hi;
    int errors = 0, samples_checked = 0, seed = 92, n, m, r;

    always #5 clk = ~clk;

    dppwm_core i_dppwm_core (.clk(clk), .reset_n(reset_n), .run_enable_wr(run_wr),
        .run_enable_wdata(run_wd), .period_flag_wr(flag_wr), .period_flag_wdata(flag_wd),
        .divider_select(div_sel), .single_shot_select(shot), .pair_invert(inv),
        .channel_pin_select(sel), .period_irq_enable(irq_en), .period_limit(per),
        .duty_compare(duty), .deadband_a(dba), .deadband_b(dbb), .core_idle(idle),
        .gpio_level(gpio), .run_enable(run_enable), .period_flag(period_flag),
        .tick_counter(tick_counter), .period_irq(period_irq), .wake_req(wake_req),
        .pin_pwm_mode(pin_pwm_mode), .pair1_out_a(pv[0]), .pair1_out_b(pv[1]),
        .pair2_out_a(pv[2]), .pair2_out_b(pv[3]));
    dppwm_load i_dppwm_load (.clk(clk), .clr(ld_clr), .en(ld_en), .pins(pv), .hi_cnt(hi));

    // every comparison passes through here
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one-cycle strobes, entered and left on a falling edge
    task automatic pulse_run(input logic v);
        run_wd = v;
        run_wr = 1'b1;
        @(negedge clk);
        run_wr = 1'b0;
    endtask

    task automatic clear_flag();
        flag_wd = 1'b0;
        flag_wr = 1'b1;
        @(negedge clk);
        flag_wr = 1'b0;
    endtask

    // bounded wait for the period flag; a hang ends the run
    task automatic wait_flag(output int cnt);
        cnt = 0;
        while (period_flag !== 1'b1 && cnt < 3000) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 3000) begin
            errors++;
            test_done();
        end
    endtask

    // expected high ticks per period on pin i
    function automatic int exp_hi(int i);
        int lim, h;
        lim = (dbb < duty) ? dbb : duty;
        // dead time covering the high time silences both sides of the pair
        if (lim <= dba) h = 0;
        else if (i % 2 == 0) h = lim - dba;
        else h = per - duty;
        if (inv[i / 2]) h = per - h;
        return h;
    endfunction

    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (5) @(negedge clk);
        check("cnt rst", tick_counter, 0);
        check("mode rst", pin_pwm_mode, 0);
        pulse_run(1'b1);
        @(negedge clk);
        check("run zero", run_enable, 0);
        $display("test reset and refusal done");
        for (int k = 0; k < 10; k++) begin
            div_sel = k[2:0];
            r = 1 << (7 - k % 8);
            per = 16'(2 + ($unsigned($random(seed)) % 8));
            // duty never above the period
            duty = (k == 0) ? per : 16'($unsigned($random(seed)) % (per + 1));
            if (k == 1) duty = 16'h0000;
            // corner: leading dead band swallows the whole pulse
            dba = (k == 2) ? 8'(duty) : 8'($unsigned($random(seed)) % 4);
            dbb = 16'($unsigned($random(seed)) % (per + 3));
            inv = 2'($random(seed));
            sel = (k < 2) ? 4'hF : 4'($random(seed));
            gpio = 4'($random(seed));
            idle = 1'($random(seed));
            clear_flag();
            pulse_run(1'b1); // settings are complete before start
            wait_flag(n);
            clear_flag();
            wait_flag(n);
            check("period", n + 1, per * r);
            m = 2 * per * r;
            ld_clr = 1'b1;
            @(negedge clk);
            ld_clr = 1'b0;
            ld_en = 1'b1;
            repeat (m) @(negedge clk);
            ld_en = 1'b0;
            for (int i = 0; i < 4; i++) begin
                check("pin high", hi[i], sel[i] ? 2 * r * exp_hi(i) : (gpio[i] ? m : 0));
            end
            check("still run", run_enable, 1);
            pulse_run(1'b0);
            repeat (2) @(negedge clk);
            check("pins stop", pv, gpio);
            check("cnt stop", tick_counter, 0);
            $display("test %0d done", k);
        end
        // interrupt gate and idle wake-up
        div_sel = 3'h7;
        per = 16'h0003;
        duty = 16'h0002; // duty kept within the shorter period
        clear_flag();
        pulse_run(1'b1);
        wait_flag(n);
        idle = 1'b1;
        @(negedge clk);
        check("irq off", period_irq, 0);
        irq_en = 1'b1;
        @(negedge clk);
        check("irq on", period_irq, 1);
        check("wake on", wake_req, 1);
        idle = 1'b0;
        @(negedge clk);
        check("wake off", wake_req, 0);
        pulse_run(1'b0);
        clear_flag();
        check("flag clr", period_flag, 0);
        $display("test interrupt done");
        // single shot, started twice
        shot = 1'b1;
        repeat (2) begin
            clear_flag();
            pulse_run(1'b1); // each pulse needs a fresh start
            wait_flag(n);
            check("shot stop", run_enable, 0);
            @(negedge clk);
            check("shot pins", pv, gpio);
        end
        $display("test single shot done");
        test_done();
    end
endmodule
